// *** core/flash_block_code_protection.sv ***
// access control for program flash, data eeprom, config bytes and id locations
`include "flash_prot_defines.svh"

module flash_block_code_protection #(
    parameter bit SMALL_MEM = 1'b0,
    parameter logic [15:0] DEV_ID = 16'h5a3c  // arbitrary value
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    // cpu table port
    input wire flash_prot_pkg::acc_req_t cpu_req_in,
    input wire logic [21:0] cpu_pc_in,
    output logic cpu_ready_out,
    // serial programmer port
    input wire flash_prot_pkg::acc_req_t prog_req_in,
    input wire flash_prot_pkg::erase_cmd_t prog_erase_in,
    output logic prog_ready_out,
    // memory array side
    output flash_prot_pkg::acc_req_t mem_req_out,
    input wire logic [7:0] mem_rdata_in,
    output flash_prot_pkg::erase_cmd_t mem_erase_out,
    // access answer
    output flash_prot_pkg::rsp_t rsp_out,
    // protection and debugger state
    output flash_prot_pkg::prot_status_t status_out,
    output logic debug_active_out,
    output logic debug_pins_reserved_out
);
    import flash_prot_pkg::*;

    // implemented bits of a bank byte
    function automatic logic [7:0] cfg_mask(input logic [2:0] idx);
        logic [7:0] m;
        m = 8'h00;
        case (idx)
            `IDX_DEBUG: m = `MASK_DEBUG;
            `IDX_RLOCK, `IDX_WLOCK, `IDX_GRANT: begin
                m = SMALL_MEM ? `MASK_LOW_SMALL : `MASK_LOW_FULL;
            end
            `IDX_BE_RLOCK: m = `MASK_BE_RLOCK;
            `IDX_BEC_WLOCK: m = `MASK_BEC_WLOCK;
            `IDX_BGRANT: m = `MASK_BGRANT;
            default: m = 8'h00;
        endcase
        return m;
    endfunction

    // {read lock, write lock, grant} of a region; locks active low, grant active high
    function automatic logic [2:0] trio_of(input cfg_bank_t c, input region_t r);
        logic [1:0] lo;
        lo = 2'(r - `RGN_0);
        if (r == `RGN_BOOT) begin
            return {c[`IDX_BE_RLOCK][`BOOT_READ_LOCK_BIT],
                    c[`IDX_BEC_WLOCK][`BOOT_WRITE_LOCK_BIT],
                    c[`IDX_BGRANT][`BOOT_GRANT_BIT]};
        end
        return {c[`IDX_RLOCK][lo], c[`IDX_WLOCK][lo], c[`IDX_GRANT][lo]};
    endfunction

    // bank index of a config address
    function automatic logic [2:0] cfg_idx(input logic [21:0] a);
        return 3'(a - `CFG_FIRST);
    endfunction

    // state
    cfg_bank_t cfg_r;
    cfg_bank_t cfg_nxt;
    stage_t s1_r;
    stage_t s1_nxt;
    acc_req_t mem_req_r;
    acc_req_t mem_req_nxt;
    erase_cmd_t erase_r;
    erase_cmd_t erase_nxt;
    rsp_t rsp_r;
    rsp_t rsp_nxt;

    // shared decode
    acc_req_t req;
    logic from_prog;
    logic take;
    addr_class_t tgt;
    addr_class_t pc_cls;
    logic [2:0] trio;
    logic [2:0] cidx;
    logic debug_active;
    logic dbg_reserved;
    logic cfg_lock_clear;
    logic cfg_wr_en;
    logic [21:0] mem_top;

    region_decode #(
        .SMALL_MEM(SMALL_MEM)
    ) u_tgt_decode (
        .addr_in(req.addr),
        .class_out(tgt)
    );

    region_decode #(
        .SMALL_MEM(SMALL_MEM)
    ) u_pc_decode (
        .addr_in(cpu_pc_in),
        .class_out(pc_cls)
    );

    // the programmer wins; the cpu waits while a programmer request is valid, nothing is queued
    assign from_prog = prog_req_in.valid;
    assign req = from_prog ? prog_req_in : cpu_req_in;
    assign take = prog_req_in.valid | cpu_req_in.valid;
    assign prog_ready_out = 1'b1;
    assign cpu_ready_out = ~prog_req_in.valid;

    assign trio = trio_of(cfg_r, tgt.region);
    assign cidx = cfg_idx(req.addr);

    // debugger active while its config bit is programmed low
    assign debug_active = ~cfg_r[`IDX_DEBUG][`DEBUG_EN_BIT];
    assign mem_top = SMALL_MEM ? `REGION2_END : `REGION3_END;
    // top of program memory belongs to the debug executive
    assign dbg_reserved = debug_active && (req.addr > (mem_top - `DBG_PROG_BYTES));

    // config lock active low; while set, firmware cannot write config bytes
    assign cfg_lock_clear = cfg_r[`IDX_BEC_WLOCK][`CONFIG_WRITE_LOCK_BIT];
    assign cfg_wr_en = take && !req.eeprom && req.write && tgt.is_cfg
                       && (from_prog || cfg_lock_clear);

    // config bank next value
    always_comb begin
        logic [7:0] old;
        logic [7:0] upd;
        logic [1:0] lo;
        old = cfg_r[cidx];
        upd = old;
        lo = 2'(prog_erase_in.region - `RGN_0);
        cfg_nxt = cfg_r;
        if (cfg_wr_en) begin
            // a written one leaves a zero bit untouched
            upd = old & (req.wdata | ~cfg_mask(cidx));
            if (!from_prog && cidx == `IDX_BEC_WLOCK) begin
                upd[`CONFIG_WRITE_LOCK_BIT] = old[`CONFIG_WRITE_LOCK_BIT];
            end
            cfg_nxt[cidx] = upd;
        end
        // erases come only over the programmer port and win over a write
        if (prog_erase_in.valid) begin
            if (prog_erase_in.chip) begin
                for (int i = 0; i < 8; i++) begin
                    cfg_nxt[i] = cfg_r[i] | cfg_mask(3'(i));
                end
            end else if (prog_erase_in.region == `RGN_BOOT) begin
                cfg_nxt[`IDX_BE_RLOCK][`BOOT_READ_LOCK_BIT] = 1'b1;
                cfg_nxt[`IDX_BEC_WLOCK][`BOOT_WRITE_LOCK_BIT] = 1'b1;
                cfg_nxt[`IDX_BGRANT][`BOOT_GRANT_BIT] = 1'b1;
            end else if (prog_erase_in.region <= `RGN_3) begin
                if (!(SMALL_MEM && prog_erase_in.region == `RGN_3)) begin
                    cfg_nxt[`IDX_RLOCK][lo] = 1'b1;
                    cfg_nxt[`IDX_WLOCK][lo] = 1'b1;
                    cfg_nxt[`IDX_GRANT][lo] = 1'b1;
                end
            end
        end
    end

    // bank is erased at power-up; protection is what the programmer, or firmware while the config lock is clear, writes
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cfg_r <= {8{`CFG_ERASED}};
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    // access decision, memory request and answer pipeline
    always_comb begin
        logic blocked;
        logic use_mem;
        logic [7:0] data;
        blocked = 1'b0;
        use_mem = 1'b0;
        data = 8'h00;
        s1_nxt = '0;
        mem_req_nxt = '0;
        erase_nxt = '0;
        rsp_nxt = '0;
        if (take) begin
            if (req.eeprom) begin
                if (from_prog && !cfg_r[`IDX_BE_RLOCK][`EEPROM_READ_LOCK_BIT]) begin
                    blocked = 1'b1;
                end else if (req.write && !cfg_r[`IDX_BEC_WLOCK][`EEPROM_WRITE_LOCK_BIT]) begin
                    blocked = 1'b1;
                end else begin
                    use_mem = 1'b1;
                end
            end else if (tgt.is_id) begin
                use_mem = 1'b1;
            end else if (tgt.is_devid) begin
                blocked = req.write;
                data = (req.addr == `DEVID_HI_ADDR) ? DEV_ID[15:8] : DEV_ID[7:0];
            end else if (tgt.is_cfg) begin
                blocked = req.write && !cfg_wr_en;
                data = cfg_r[cidx] & cfg_mask(cidx);
            end else if (tgt.is_user) begin
                if (from_prog && !trio[2]) begin
                    blocked = 1'b1;
                end else if (!from_prog && req.write && (!trio[1] || dbg_reserved)) begin
                    blocked = 1'b1;
                end else if (!from_prog && !req.write && !trio[0]
                             && pc_cls.region != tgt.region) begin
                    blocked = 1'b1;
                end else begin
                    use_mem = 1'b1;
                end
            end else begin
                // unimplemented space reads zero, writes are dropped
                blocked = req.write;
            end
            s1_nxt.valid = 1'b1;
            s1_nxt.from_prog = from_prog;
            s1_nxt.blocked = blocked;
            s1_nxt.rd_mem = use_mem && !req.write;
            s1_nxt.data = blocked ? 8'h00 : data;
            // refused requests never reach the array
            mem_req_nxt.valid = use_mem;
            mem_req_nxt.write = req.write;
            mem_req_nxt.eeprom = req.eeprom;
            mem_req_nxt.addr = req.addr;
            mem_req_nxt.wdata = req.wdata;
        end
        if (prog_erase_in.valid) begin
            erase_nxt = prog_erase_in;
        end
        // array read data is taken while the registered request stands
        rsp_nxt.valid = s1_r.valid;
        rsp_nxt.from_prog = s1_r.from_prog;
        rsp_nxt.blocked = s1_r.blocked;
        rsp_nxt.data = s1_r.rd_mem ? mem_rdata_in : s1_r.data;
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s1_r <= '0;
            mem_req_r <= '0;
            erase_r <= '0;
            rsp_r <= '0;
        end else begin
            s1_r <= s1_nxt;
            mem_req_r <= mem_req_nxt;
            erase_r <= erase_nxt;
            rsp_r <= rsp_nxt;
        end
    end

    assign mem_req_out = mem_req_r;
    assign mem_erase_out = erase_r;
    assign rsp_out = rsp_r;

    // status straight from the bank; bit 0 is the boot region
    assign status_out.read_lock = {cfg_r[`IDX_RLOCK][3:0],
                                   cfg_r[`IDX_BE_RLOCK][`BOOT_READ_LOCK_BIT]};
    assign status_out.write_lock = {cfg_r[`IDX_WLOCK][3:0],
                                    cfg_r[`IDX_BEC_WLOCK][`BOOT_WRITE_LOCK_BIT]};
    assign status_out.table_read_grant = {cfg_r[`IDX_GRANT][3:0],
                                          cfg_r[`IDX_BGRANT][`BOOT_GRANT_BIT]};
    assign status_out.eeprom_read_lock = cfg_r[`IDX_BE_RLOCK][`EEPROM_READ_LOCK_BIT];
    assign status_out.eeprom_write_lock = cfg_r[`IDX_BEC_WLOCK][`EEPROM_WRITE_LOCK_BIT];
    assign status_out.config_write_lock = cfg_lock_clear;
    assign debug_active_out = debug_active;
    // debug clock and data pins are taken from the port logic
    assign debug_pins_reserved_out = debug_active;

endmodule

// *** core/flash_prot_defines.svh ***
// address map, field positions and constants of the flash protection block
`ifndef FLASH_PROT_DEFINES_SVH
`define FLASH_PROT_DEFINES_SVH

// program memory regions, inclusive upper bounds
`define BOOT_END 22'h0007ff
`define REGION0_END 22'h001fff
`define REGION1_END 22'h003fff
`define REGION2_END 22'h005fff
`define REGION3_END 22'h007fff

// region codes
`define RGN_BOOT 3'd0
`define RGN_0 3'd1
`define RGN_1 3'd2
`define RGN_2 3'd3
`define RGN_3 3'd4
`define RGN_NONE 3'd7

// user id locations
`define ID_FIRST 22'h200000
`define ID_LAST 22'h200007

// device identification word, two bytes
`define DEVID_LO_ADDR 22'h3ffffe
`define DEVID_HI_ADDR 22'h3fffff

// configuration bytes held here
`define DEBUG_CFG_ADDR 22'h300006
`define REGION_READ_LOCK_LOW_ADDR 22'h300008
`define BOOT_EEPROM_READ_LOCK_ADDR 22'h300009
`define REGION_WRITE_LOCK_LOW_ADDR 22'h30000a
`define BOOT_EEPROM_CFG_WRITE_LOCK_ADDR 22'h30000b
`define REGION_READ_GRANT_LOW_ADDR 22'h30000c
`define BOOT_READ_GRANT_ADDR 22'h30000d
`define CFG_FIRST `DEBUG_CFG_ADDR
`define CFG_LAST `BOOT_READ_GRANT_ADDR

// bank indices (address minus first config address)
`define IDX_DEBUG 3'd0
`define IDX_RLOCK 3'd2
`define IDX_BE_RLOCK 3'd3
`define IDX_WLOCK 3'd4
`define IDX_BEC_WLOCK 3'd5
`define IDX_GRANT 3'd6
`define IDX_BGRANT 3'd7

// field positions
`define DEBUG_EN_BIT 7
`define EEPROM_READ_LOCK_BIT 7
`define BOOT_READ_LOCK_BIT 6
`define EEPROM_WRITE_LOCK_BIT 7
`define BOOT_WRITE_LOCK_BIT 6
`define CONFIG_WRITE_LOCK_BIT 5
`define BOOT_GRANT_BIT 6

// implemented bits per bank byte
`define MASK_DEBUG 8'h80
`define MASK_LOW_FULL 8'h0f
`define MASK_LOW_SMALL 8'h07
`define MASK_BE_RLOCK 8'hc0
`define MASK_BEC_WLOCK 8'he0
`define MASK_BGRANT 8'h40
`define CFG_ERASED 8'hff

// debugger reservations
`define DBG_STACK_LEVELS 2
`define DBG_PROG_BYTES 22'd512
`define DBG_DATA_BYTES 10

`endif

// *** core/flash_prot_pkg.sv ***
// types shared by the flash protection block
package flash_prot_pkg;

    typedef logic [2:0] region_t;
    typedef logic [7:0][7:0] cfg_bank_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic eeprom;
        logic [21:0] addr;
        logic [7:0] wdata;
    } acc_req_t;

    typedef struct packed {
        logic valid;
        logic chip;
        region_t region;
    } erase_cmd_t;

    typedef struct packed {
        logic valid;
        logic from_prog;
        logic blocked;
        logic [7:0] data;
    } rsp_t;

    typedef struct packed {
        region_t region;
        logic is_user;
        logic is_id;
        logic is_cfg;
        logic is_devid;
    } addr_class_t;

    typedef struct packed {
        logic valid;
        logic from_prog;
        logic blocked;
        logic rd_mem;
        logic [7:0] data;
    } stage_t;

    typedef struct packed {
        logic [4:0] read_lock;
        logic [4:0] write_lock;
        logic [4:0] table_read_grant;
        logic eeprom_read_lock;
        logic eeprom_write_lock;
        logic config_write_lock;
    } prot_status_t;

endpackage

// *** core/region_decode.sv ***
// classifies a table address into protection region and space
`include "flash_prot_defines.svh"

module region_decode #(
    parameter bit SMALL_MEM = 1'b0
) (
    // address to classify
    input wire logic [21:0] addr_in,
    // classification
    output flash_prot_pkg::addr_class_t class_out
);
    import flash_prot_pkg::*;

    always_comb begin
        class_out = '0;
        class_out.region = `RGN_NONE;
        if (addr_in <= `BOOT_END) begin
            class_out.region = `RGN_BOOT;
        end else if (addr_in <= `REGION0_END) begin
            class_out.region = `RGN_0;
        end else if (addr_in <= `REGION1_END) begin
            class_out.region = `RGN_1;
        end else if (addr_in <= `REGION2_END) begin
            class_out.region = `RGN_2;
        end else if (addr_in <= `REGION3_END && !SMALL_MEM) begin
            class_out.region = `RGN_3;
        end
        class_out.is_user = (class_out.region != `RGN_NONE);
        class_out.is_id = (addr_in >= `ID_FIRST) && (addr_in <= `ID_LAST);
        class_out.is_cfg = (addr_in >= `CFG_FIRST) && (addr_in <= `CFG_LAST);
        class_out.is_devid = (addr_in == `DEVID_LO_ADDR) || (addr_in == `DEVID_HI_ADDR);
    end

endmodule

// *** dv/flash_array_model.sv ***
// behavioural program array answering the block's memory port
module flash_array_model
    import flash_prot_pkg::*;
(
    // array port
    input wire logic sys_clk_in,
    input wire flash_prot_pkg::acc_req_t mem_req_in,
    output logic [7:0] mem_rdata_out,
    output int write_count_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] last_r = 8'h00;
    initial write_count_out = 0;
    // contents follow the address so a wrong address shows up as wrong data
    always_comb begin
        if (mem_req_in.valid) begin
            mem_rdata_out = mem_req_in.addr[7:0] ^ 8'h5a;
        end else begin
            // idle bus never repeats the last byte
            mem_rdata_out = ~last_r;
        end
    end
    always @(posedge sys_clk_in) begin
        if (mem_req_in.valid) begin
            last_r <= mem_rdata_out;
        end
        if (mem_req_in.valid && mem_req_in.write) begin
            write_count_out <= write_count_out + 1;
        end
    end
endmodule

// *** dv/flash_prot_checker.sv ***
// concurrent checks on the ports of the flash protection block
module flash_prot_checker
    import flash_prot_pkg::*;
(
    // everything watched
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire flash_prot_pkg::acc_req_t cpu_req_in,
    input wire logic [21:0] cpu_pc_in,
    input wire logic cpu_ready_out,
    input wire flash_prot_pkg::acc_req_t prog_req_in,
    input wire flash_prot_pkg::erase_cmd_t prog_erase_in,
    input wire logic prog_ready_out,
    input wire flash_prot_pkg::acc_req_t mem_req_out,
    input wire logic [7:0] mem_rdata_in,
    input wire flash_prot_pkg::erase_cmd_t mem_erase_out,
    input wire flash_prot_pkg::rsp_t rsp_out,
    input wire flash_prot_pkg::prot_status_t status_out,
    input wire logic debug_active_out,
    input wire logic debug_pins_reserved_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);
    logic [17:0] st_bits;
    logic taken;
    logic quiet;
    assign st_bits = status_out;
    assign taken = prog_req_in.valid || (cpu_req_in.valid && cpu_ready_out);
    assign quiet = !prog_req_in.valid && !prog_erase_in.valid;

    chk_rsp_two_cycles: assert property (taken |-> ##2 rsp_out.valid)
        else $error("answer missing two cycles after request");
    chk_blocked_zero: assert property (rsp_out.valid && rsp_out.blocked |-> rsp_out.data == 8'h00)
        else $error("refused answer carries data");
    chk_mem_data: assert property (mem_req_out.valid && !mem_req_out.write |=>
        rsp_out.valid && !rsp_out.blocked && rsp_out.data == $past(mem_rdata_in))
        else $error("array data not passed to answer");
    chk_lock_one_way: assert property (!prog_erase_in.valid |=> (st_bits & ~$past(st_bits)) == 18'h0)
        else $error("protection bit set without erase");
    chk_chip_erase_all: assert property (prog_erase_in.valid && prog_erase_in.chip |=>
        st_bits == 18'h3ffff)
        else $error("chip erase left a bit clear");
    chk_erase_echo: assert property (prog_erase_in.valid |=>
        mem_erase_out.valid && mem_erase_out.region == $past(prog_erase_in.region))
        else $error("erase not forwarded to array");
    chk_cfg_lock_held: assert property (quiet [*2] |=> $stable(status_out.config_write_lock))
        else $error("config lock moved without programmer");
    chk_debug_pins: assert property (debug_pins_reserved_out == debug_active_out)
        else $error("debug pin reservation differs from debug state");
    chk_refused_no_mem: assert property (rsp_out.valid && rsp_out.blocked |-> !$past(mem_req_out.valid))
        else $error("refused access reached the array");
    chk_grant_outside: assert property (cpu_req_in.valid && cpu_ready_out && !cpu_req_in.write
        && !cpu_req_in.eeprom && cpu_req_in.addr inside {[22'h000800:22'h001fff]}
        && !status_out.table_read_grant[1] && !(cpu_pc_in inside {[22'h000800:22'h001fff]})
        |-> ##2 (rsp_out.blocked && rsp_out.data == 8'h00))
        else $error("outside table read not zeroed");

    cov_blocked: cover property (rsp_out.valid && rsp_out.blocked);
    cov_chip_erase: cover property (mem_erase_out.valid && mem_erase_out.chip);
    cov_mem_write: cover property (mem_req_out.valid && mem_req_out.write);
endmodule

bind flash_block_code_protection flash_prot_checker u_chk (
    .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .cpu_req_in(cpu_req_in),
    .cpu_pc_in(cpu_pc_in), .cpu_ready_out(cpu_ready_out), .prog_req_in(prog_req_in),
    .prog_erase_in(prog_erase_in), .prog_ready_out(prog_ready_out),
    .mem_req_out(mem_req_out), .mem_rdata_in(mem_rdata_in), .mem_erase_out(mem_erase_out),
    .rsp_out(rsp_out), .status_out(status_out), .debug_active_out(debug_active_out),
    .debug_pins_reserved_out(debug_pins_reserved_out)
);

// *** dv/test_flash_block_code_protection.sv ***
// self-checking bench for the flash protection block
module test_flash_block_code_protection;
    import flash_prot_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_in, rstn_in, cpu_ready, prog_ready, dbg_act, dbg_pins;
    acc_req_t cpu_req, prog_req, mem_req;
    erase_cmd_t erase, mem_erase;
    logic [21:0] pc;
    logic [7:0] mem_rdata;
    rsp_t rsp;
    prot_status_t st;
    int fail_count = 0, compares = 0, mem_writes, w0;

    flash_block_code_protection u_dut (
        .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .cpu_req_in(cpu_req), .cpu_pc_in(pc),
        .cpu_ready_out(cpu_ready), .prog_req_in(prog_req), .prog_erase_in(erase),
        .prog_ready_out(prog_ready), .mem_req_out(mem_req), .mem_rdata_in(mem_rdata),
        .mem_erase_out(mem_erase), .rsp_out(rsp), .status_out(st),
        .debug_active_out(dbg_act), .debug_pins_reserved_out(dbg_pins)
    );
    flash_array_model u_mem (
        .sys_clk_in(sys_clk_in), .mem_req_in(mem_req), .mem_rdata_out(mem_rdata),
        .write_count_out(mem_writes)
    );

    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask

    // one request from either port, then wait for its answer
    task automatic acc(input logic p, input logic wr, input logic ee, input logic [21:0] a,
                       input logic [7:0] d, input logic eb, input logic [7:0] ed);
        acc_req_t r;
        int n;
        r = '{valid: 1'b1, write: wr, eeprom: ee, addr: a, wdata: d};
        n = 0;
        @(negedge sys_clk_in);
        if (p) prog_req = r;
        else cpu_req = r;
        @(negedge sys_clk_in);
        prog_req = '0;
        cpu_req = '0;
        while (rsp.valid !== 1'b1 && n < 4) begin
            @(negedge sys_clk_in);
            n++;
        end
        check("rsp valid", 32'h1, {31'h0, rsp.valid});
        check("rsp blocked", {31'h0, eb}, {31'h0, rsp.blocked});
        check("rsp source", {31'h0, p}, {31'h0, rsp.from_prog});
        if (!wr) check("rsp data", {24'h0, ed}, {24'h0, rsp.data});
    endtask

    task automatic erase_cmd(input logic c, input region_t rg);
        @(negedge sys_clk_in);
        erase = '{valid: 1'b1, chip: c, region: rg};
        @(negedge sys_clk_in);
        erase = '0;
        @(negedge sys_clk_in);
    endtask

    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        #100us;
        fail_count++;
        report_and_stop();
    end

    // programmer config writes keep region 3 bits set, as the programmer must; only the refused cpu write of f7 tries to clear one
    initial begin
        rstn_in = 1'b0;
        cpu_req = '0;
        prog_req = '0;
        erase = '0;
        pc = 22'h000900;
        repeat (3) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        rstn_in = 1'b1;
        check("status", 32'h3ffff, {14'h0, st});
        check("debug", 32'h0, {31'h0, dbg_act});
        acc(0, 0, 0, 22'h000923, 8'h00, 0, 8'h79);
        acc(1, 1, 0, 22'h30000c, 8'hfe, 0, 8'h00);
        pc = 22'h000100;
        acc(0, 0, 0, 22'h000923, 8'h00, 1, 8'h00);
        pc = 22'h000a00;
        acc(0, 0, 0, 22'h000923, 8'h00, 0, 8'h79);
        acc(1, 1, 0, 22'h30000c, 8'hff, 0, 8'h00);
        acc(1, 0, 0, 22'h30000c, 8'h00, 0, 8'h0e);
        acc(1, 1, 0, 22'h30000a, 8'hfd, 0, 8'h00);
        w0 = mem_writes;
        acc(0, 1, 0, 22'h002100, 8'h11, 1, 8'h00);
        check("array writes", w0, mem_writes);
        acc(0, 1, 0, 22'h004100, 8'h11, 0, 8'h00);
        check("array writes", w0 + 1, mem_writes);
        acc(1, 1, 0, 22'h300008, 8'hfb, 0, 8'h00);
        pc = 22'h004000;
        acc(0, 0, 0, 22'h004044, 8'h00, 0, 8'h1e);
        acc(1, 0, 0, 22'h004044, 8'h00, 1, 8'h00);
        acc(1, 0, 0, 22'h200003, 8'h00, 0, 8'h59);
        acc(0, 1, 0, 22'h200007, 8'h33, 0, 8'h00);
        acc(0, 0, 0, 22'h3ffffe, 8'h00, 0, 8'h3c);
        acc(0, 0, 0, 22'h3fffff, 8'h00, 0, 8'h5a);
        acc(1, 1, 0, 22'h300009, 8'h7f, 0, 8'h00);
        acc(1, 0, 1, 22'h000010, 8'h00, 1, 8'h00);
        acc(0, 0, 1, 22'h000010, 8'h00, 0, 8'h4a);
        acc(0, 1, 1, 22'h000010, 8'h01, 0, 8'h00);
        acc(1, 1, 0, 22'h30000b, 8'h7f, 0, 8'h00);
        acc(0, 1, 1, 22'h000010, 8'h01, 1, 8'h00);
        acc(0, 1, 0, 22'h30000b, 8'hdf, 0, 8'h00);
        check("config lock", 32'h1, {31'h0, st.config_write_lock});
        acc(1, 1, 0, 22'h30000b, 8'hdf, 0, 8'h00);
        check("config lock", 32'h0, {31'h0, st.config_write_lock});
        acc(0, 1, 0, 22'h300008, 8'hf7, 1, 8'h00);
        @(negedge sys_clk_in);
        cpu_req = '{valid: 1'b1, write: 1'b0, eeprom: 1'b0, addr: 22'h000900, wdata: 8'h00};
        prog_req = '{valid: 1'b1, write: 1'b0, eeprom: 1'b0, addr: 22'h200000, wdata: 8'h00};
        #1 check("cpu ready", 32'h0, {31'h0, cpu_ready});
        check("prog ready", 32'h1, {31'h0, prog_ready});
        @(negedge sys_clk_in);
        cpu_req = '0;
        prog_req = '0;
        // the programmer's answer must drain before the next access; the yielded cpu request gets none
        repeat (3) @(negedge sys_clk_in);
        acc(1, 1, 0, 22'h300006, 8'h7f, 0, 8'h00);
        check("debug", 32'h3, {30'h0, dbg_act, dbg_pins});
        acc(0, 1, 0, 22'h007f00, 8'h01, 1, 8'h00);
        erase_cmd(1'b0, 3'd2);
        check("region1 write lock", 32'h1, {31'h0, st.write_lock[2]});
        check("region2 read lock", 32'h0, {31'h0, st.read_lock[3]});
        erase_cmd(1'b1, 3'd0);
        check("status", 32'h3ffff, {14'h0, st});
        check("debug", 32'h0, {31'h0, dbg_act});
        report_and_stop();
    end
endmodule
